// File: src/ftm_pkg.sv
/*
 * ftm_pkg: register map, field positions, reset values and encodings for the
 * fifo watermark / timer / mode control register bank.
 * Assumes a single 50 MHz clock and an 8-bit register view on a 32-bit bus.
 */
package ftm_pkg;

    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_FIFO_DATA_PORT  = 8'h09;
    localparam logic [7:0] IDX_FIFO_LEVEL      = 8'h0A;
    localparam logic [7:0] IDX_FIFO_WATERMARK  = 8'h0B;
    localparam logic [7:0] IDX_MISC_CONTROL    = 8'h0C;
    localparam logic [7:0] IDX_COLLISION_POS   = 8'h0E;
    localparam logic [7:0] IDX_GENERAL_MODE    = 8'h11;
    localparam logic [7:0] IDX_RX_LAST_BITS    = 8'h20;
    localparam logic [7:0] IDX_IRQ_STATUS      = 8'h21;
    localparam logic [7:0] IDX_IRQ_ENABLE      = 8'h22;
    localparam logic [7:0] IDX_IRQ_CLEAR       = 8'h23;
    localparam logic [7:0] IDX_CHECKSUM_START  = 8'h24;
    localparam logic [7:0] IDX_CARD_ID_BASE    = 8'h30;

    // reset values
    localparam logic [5:0] RST_FIFO_WATERMARK  = 6'h08;
    localparam logic [7:0] RST_GENERAL_MODE    = 8'h3B;

    // misc control fields
    localparam int BIT_TIMER_HALT   = 7;
    localparam int BIT_TIMER_GO     = 6;
    localparam int BIT_CARD_ID_LOAD = 5;

    // general mode fields
    localparam int BIT_HIGH_FIRST   = 7;
    localparam int BIT_SYNC_ENABLE  = 6;
    localparam int BIT_MODE_DET_OFF = 2;

    // collision register fixed upper bits
    localparam logic [2:0] COLL_FIXED_BITS = 3'h5;

    // fifo geometry and card identifier
    localparam int         FIFO_DEPTH     = 64;
    localparam int         CARD_ID_BYTES  = 10;
    localparam logic [6:0] FIFO_DEPTH_CNT = 7'h40;
    localparam logic [7:0] SYNC_BYTE      = 8'hF0;

    // checksum start values per preset code
    localparam logic [15:0] CRC_PRESET_0 = 16'h0000;
    localparam logic [15:0] CRC_PRESET_1 = 16'h6363;
    localparam logic [15:0] CRC_PRESET_2 = 16'hA671;
    localparam logic [15:0] CRC_PRESET_3 = 16'hFFFF;

    // interrupt status bit positions
    localparam int IRQ_NEAR_FULL  = 0;
    localparam int IRQ_NEAR_EMPTY = 1;
    localparam int IRQ_ID_LOADED  = 2;
    localparam int IRQ_OVERFLOW   = 3;
    localparam int IRQ_W          = 4;

    typedef enum logic [1:0] {
        FTM_IDLE,
        FTM_LOAD,
        FTM_DONE
    } ftm_load_e;

endpackage : ftm_pkg

// File: src/ftm_regs.sv
/*
 * ftm_regs: avalon-mm slave register bank holding the fifo watermark, the
 * miscellaneous control strobes, collision and general mode registers, a
 * 64-byte fifo reached through its data port, and the card identifier copy.
 * Assumes the timer, checksum engine and rf framing sit outside and use the
 * strobes and settings driven here; rx_last_bits comes from the receiver.
 */
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps

// Contract
// - near-full flag set when free fifo space is at or below watermark.
// - near-empty flag set when fifo byte count is at or below watermark.
// - watermark is six-bit read/write, top two bits read zero, resets to eight.
// - writing one to the halt strobe stops the timer at once.
// - writing one to the go strobe starts the timer at once; the code drops go when halt is set in the same write.
// - halt and go strobe bits always read back as zero.
// - setting identifier-load copies the ten stored identifier bytes into the fifo.
// - identifier-load bit clears itself after the copy finishes.
// - three-bit read-only field gives valid bits of last byte; zero means all.
// - misc control resets to zero; bits four and three read zero.
// - collision register reads 101 on top; low five bits carry no meaning.
// - general mode register is full read/write and resets to 3Bh.
// - general mode settings apply to both transmit and receive directions.
// - checksum preset code selects start value 0000, 6363, A671 or FFFF.
// - fifo byte count rises on data-port write, falls on data-port read.
// - sync enable makes receiver wait for F0h and transmitter prepend F0h.
module ftm_regs
    import ftm_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [2:0]  rx_last_bits,
    output logic             timer_running,
    output logic             timer_go_strobe,
    output logic             timer_halt_strobe,
    output logic             checksum_high_bit_first,
    output logic             sync_byte_enable,
    output logic [7:0]       sync_byte_value,
    output logic             mode_detector_disable,
    output logic [15:0]      checksum_start_value,
    output logic             fifo_near_full_flag,
    output logic             fifo_near_empty_flag,
    output logic             irq
);

    // storage: fifo bytes and the stored card identifier
    logic [7:0]  fifo_mem [FIFO_DEPTH];
    logic [7:0]  card_id  [CARD_ID_BYTES];

    // software-visible register state
    logic [5:0]  fifo_watermark_count;
    logic [7:0]  general_mode;
    logic        card_id_load_strobe;

    // fifo bookkeeping
    logic [6:0]  fifo_byte_count;
    logic [5:0]  wr_ptr;
    logic [5:0]  rd_ptr;

    // identifier copy engine
    logic [3:0]  load_idx;
    ftm_load_e   load_state;

    // interrupt status, enable and per-cycle events
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_event;

    // bus decode
    logic        ack;
    logic [7:0]  idx;
    logic        wr_hit;
    logic        rd_hit;

    // fifo push and pop qualifiers
    logic        port_push;
    logic        port_pop;
    logic        id_push;
    logic        push;
    logic        fifo_full;

    // edge detectors and read path
    logic        near_full_q;
    logic        near_empty_q;
    logic [7:0]  next_rdata;
    logic [6:0]  free_space;

    // bus timing in short:
    // c0: request raised, waitrequest high
    // c1: ack high, waitrequest low
    // the edge that ends c1 commits a write
    // read data is captured at the end of c0
    // so it already stands during c1
    // each access costs two cycles
    // back to back accesses are allowed
    // only byte lane zero carries data
    // byte enable zero low drops a write
    // index is the byte address over four,
    // since some indices are not word aligned

    // one wait state per access: waitrequest drops in the cycle after a request
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign idx             = avs_address[9:2];
    assign wr_hit          = avs_write && ack && avs_byteenable[0];
    assign rd_hit          = avs_read && ack;

    // fifo push sources: data port writes, then identifier copy when the port is quiet
    assign fifo_full  = (fifo_byte_count == FIFO_DEPTH_CNT);
    assign port_push  = wr_hit && (idx == IDX_FIFO_DATA_PORT) && !fifo_full;
    assign port_pop   = rd_hit && (idx == IDX_FIFO_DATA_PORT) && (fifo_byte_count != 7'h00);
    assign id_push    = (load_state == FTM_LOAD) && !fifo_full && !port_push;
    assign push       = port_push || id_push;
    assign free_space = FIFO_DEPTH_CNT - fifo_byte_count;

    // alert comparisons are continuous against the live count
    // the flags are levels, not events; the
    // interrupt side turns their rises into
    // sticky status bits further below
    assign fifo_near_full_flag  = (free_space <= {1'b0, fifo_watermark_count});
    assign fifo_near_empty_flag = (fifo_byte_count <= {1'b0, fifo_watermark_count});

    // watermark register, six bits kept, upper bits never stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            fifo_watermark_count <= RST_FIFO_WATERMARK;
        end else if (wr_hit && idx == IDX_FIFO_WATERMARK) begin
            fifo_watermark_count <= avs_writedata[5:0];
        end
    end

    // timer strobes are one-cycle pulses, halt beats go in the same write
    // strobes are never stored, so a read of
    // bits seven and six always returns zero
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_go_strobe   <= 1'b0;
            timer_halt_strobe <= 1'b0;
        end else begin
            timer_halt_strobe <= wr_hit && idx == IDX_MISC_CONTROL
                                 && avs_writedata[BIT_TIMER_HALT];
            timer_go_strobe   <= wr_hit && idx == IDX_MISC_CONTROL
                                 && avs_writedata[BIT_TIMER_GO]
                                 && !avs_writedata[BIT_TIMER_HALT];
        end
    end

    // timer run state follows the strobes in the cycle after the write
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_running <= 1'b0;
        end else if (timer_halt_strobe) begin
            timer_running <= 1'b0;
        end else if (timer_go_strobe) begin
            timer_running <= 1'b1;
        end
    end

    // general mode register, every bit read/write
    // reserved bits are kept as written so
    // software sees back what it stored
    always_ff @(posedge mclk) begin
        if (rst) begin
            general_mode <= RST_GENERAL_MODE;
        end else if (wr_hit && idx == IDX_GENERAL_MODE) begin
            general_mode <= avs_writedata[7:0];
        end
    end

    // mode settings drive both directions of the rf path alike
    assign checksum_high_bit_first = general_mode[BIT_HIGH_FIRST];
    assign sync_byte_enable        = general_mode[BIT_SYNC_ENABLE];
    assign sync_byte_value         = SYNC_BYTE;
    assign mode_detector_disable   = general_mode[BIT_MODE_DET_OFF];

    // checksum preset decode
    // only the software-started checksum uses
    // this; rf traffic picks its own preset
    always_comb begin
        case (general_mode[1:0])
            2'h0:    checksum_start_value = CRC_PRESET_0;
            2'h1:    checksum_start_value = CRC_PRESET_1;
            2'h2:    checksum_start_value = CRC_PRESET_2;
            default: checksum_start_value = CRC_PRESET_3;
        endcase
    end

    // card identifier storage, written byte by byte from software
    // cleared by reset so a copy before any
    // write yields ten zero bytes
    generate
        for (genvar i = 0; i < CARD_ID_BYTES; i++) begin : g_card_id
            always_ff @(posedge mclk) begin
                if (rst) begin
                    card_id[i] <= 8'h00;
                end else if (wr_hit && idx == IDX_CARD_ID_BASE + 8'(i)) begin
                    card_id[i] <= avs_writedata[7:0];
                end
            end
        end
    endgenerate

    // identifier copy engine; a full fifo stalls it rather than dropping bytes
    // one byte per cycle, card_id[0] first
    // a data port push in the same cycle wins
    // the write port; the copy waits a cycle
    // the load bit reads one during the copy
    // and drops a cycle after the last byte
    // limitation: a flush during a copy does
    // not stop it; only later bytes remain
    // a second load write mid-copy is ignored
    always_ff @(posedge mclk) begin
        if (rst) begin
            load_state          <= FTM_IDLE;
            load_idx            <= 4'h0;
            card_id_load_strobe <= 1'b0;
        end else begin
            case (load_state)
                FTM_IDLE: begin
                    if (wr_hit && idx == IDX_MISC_CONTROL
                        && avs_writedata[BIT_CARD_ID_LOAD]) begin
                        card_id_load_strobe <= 1'b1;
                        load_idx            <= 4'h0;
                        load_state          <= FTM_LOAD;
                    end
                end
                FTM_LOAD: begin
                    if (id_push) begin
                        load_idx <= load_idx + 4'h1;
                        if (load_idx == 4'(CARD_ID_BYTES - 1)) begin
                            load_state <= FTM_DONE;
                        end
                    end
                end
                FTM_DONE: begin
                    card_id_load_strobe <= 1'b0;
                    load_state          <= FTM_IDLE;
                end
                default: begin
                    load_state <= FTM_IDLE;
                end
            endcase
        end
    end

    // fifo storage
    always_ff @(posedge mclk) begin
        if (push) begin
            fifo_mem[wr_ptr] <= port_push ? avs_writedata[7:0] : card_id[load_idx];
        end
    end

    // pointers and byte count; flush through the level register clears both
    // push and pop in one cycle leave the
    // count as it was; both pointers move
    always_ff @(posedge mclk) begin
        if (rst || (wr_hit && idx == IDX_FIFO_LEVEL && avs_writedata[7])) begin
            wr_ptr          <= 6'h00;
            rd_ptr          <= 6'h00;
            fifo_byte_count <= 7'h00;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 6'h01;
            end
            if (port_pop) begin
                rd_ptr <= rd_ptr + 6'h01;
            end
            case ({push, port_pop})
                2'b10:   fifo_byte_count <= fifo_byte_count + 7'h01;
                2'b01:   fifo_byte_count <= fifo_byte_count - 7'h01;
                default: fifo_byte_count <= fifo_byte_count;
            endcase
        end
    end

    // alert edges feed the interrupt status; overflow is a write to a full fifo
    // the delayed copies reset to the idle
    // level of their flags, so reset itself
    // raises no false near-empty event
    always_ff @(posedge mclk) begin
        if (rst) begin
            near_full_q  <= 1'b0;
            near_empty_q <= 1'b1; // empty fifo is near empty
        end else begin
            near_full_q  <= fifo_near_full_flag;
            near_empty_q <= fifo_near_empty_flag;
        end
    end

    assign irq_event[IRQ_NEAR_FULL]  = fifo_near_full_flag && !near_full_q;
    assign irq_event[IRQ_NEAR_EMPTY] = fifo_near_empty_flag && !near_empty_q;
    assign irq_event[IRQ_ID_LOADED]  = (load_state == FTM_DONE);
    assign irq_event[IRQ_OVERFLOW]   = wr_hit && idx == IDX_FIFO_DATA_PORT && fifo_full;

    // sticky status: a new event beats a clear in the same cycle
    // clear is write-one-per-bit; zeros in the
    // written byte leave their bits alone
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_status <= '0;
        end else if (wr_hit && idx == IDX_IRQ_CLEAR) begin
            irq_status <= (irq_status & ~avs_writedata[IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_enable <= '0;
        end else if (wr_hit && idx == IDX_IRQ_ENABLE) begin
            irq_enable <= avs_writedata[IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_enable);

    // read mux; unmapped indices read zero
    // a data port read of an empty fifo gives
    // a stale byte and leaves the count alone
    always_comb begin
        next_rdata = 8'h00;
        case (idx)
            IDX_FIFO_DATA_PORT: next_rdata = fifo_mem[rd_ptr];
            IDX_FIFO_LEVEL:     next_rdata = {1'b0, fifo_byte_count};
            IDX_FIFO_WATERMARK: next_rdata = {2'b00, fifo_watermark_count};
            IDX_MISC_CONTROL:   next_rdata = {2'b00, card_id_load_strobe,
                                              2'b00, rx_last_bits};
            IDX_COLLISION_POS:  next_rdata = {COLL_FIXED_BITS, 5'h00};
            IDX_GENERAL_MODE:   next_rdata = general_mode;
            IDX_RX_LAST_BITS:   next_rdata = {5'h00, rx_last_bits};
            IDX_IRQ_STATUS:     next_rdata = {4'h0, irq_status};
            IDX_IRQ_ENABLE:     next_rdata = {4'h0, irq_enable};
            IDX_CHECKSUM_START: next_rdata = {4'h0, fifo_near_empty_flag, fifo_near_full_flag,
                                              general_mode[1:0]};
            default:            next_rdata = 8'h00;
        endcase
    end

    // read data registered so it stands at the edge waitrequest is low
    always_ff @(posedge mclk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= {24'h000000, next_rdata};
        end
    end

endmodule : ftm_regs

// File: tb/ftm_regs_assertions.sv
/* ftm_regs_assertions: protocol checks on strobes, readback and settings.
   Assumes a bind to ftm_regs, one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module ftm_regs_assertions
    import ftm_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [2:0]  rx_last_bits,
    input wire logic        timer_running,
    input wire logic        timer_go_strobe,
    input wire logic        timer_halt_strobe,
    input wire logic        sync_byte_enable,
    input wire logic [7:0]  sync_byte_value,
    input wire logic [15:0] checksum_start_value
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // accesses take effect only at the edge where waitrequest is low
    wire       wr_ack = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire       rd_ack = avs_read && !avs_waitrequest;
    wire [7:0] idx    = avs_address[9:2];
    wire [7:0] wd     = avs_writedata[7:0];
    property p_go;
        wr_ack && idx == IDX_MISC_CONTROL && wd[7:6] == 2'b01 |=> timer_go_strobe ##1 timer_running;
    endproperty
    a_go: assert property (p_go) else $error("go write did not start timer");
    property p_halt;
        wr_ack && idx == IDX_MISC_CONTROL && wd[7] |=> timer_halt_strobe ##1 !timer_running;
    endproperty
    a_halt: assert property (p_halt) else $error("halt write did not stop timer");
    property p_both;
        wr_ack && idx == IDX_MISC_CONTROL && wd[7:6] == 2'b11 |=> !timer_go_strobe [*2];
    endproperty
    a_both: assert property (p_both) else $error("go strobe with halt");
    property p_strobe_read;
        rd_ack && idx == IDX_MISC_CONTROL |-> avs_readdata[7:6] == 2'b00;
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe bits read set");
    property p_misc_zero;
        rd_ack && idx == IDX_MISC_CONTROL |-> avs_readdata[4:3] == 2'b00;
    endproperty
    a_misc_zero: assert property (p_misc_zero) else $error("misc bits 4:3 set");
    property p_last_bits;
        rd_ack && idx == IDX_MISC_CONTROL |-> avs_readdata[2:0] == $past(rx_last_bits);
    endproperty
    a_last_bits: assert property (p_last_bits) else $error("last bits wrong");
    property p_wm_top;
        rd_ack && idx == IDX_FIFO_WATERMARK |-> avs_readdata[7:6] == 2'b00;
    endproperty
    a_wm_top: assert property (p_wm_top) else $error("watermark top bits set");
    property p_coll;
        rd_ack && idx == IDX_COLLISION_POS |-> avs_readdata[7:5] == 3'b101;
    endproperty
    a_coll: assert property (p_coll) else $error("collision top bits wrong");
    property p_preset;
        wr_ack && idx == IDX_GENERAL_MODE |=> checksum_start_value ==
            ($past(wd[1]) ? ($past(wd[0]) ? 16'hFFFF : 16'hA671) : ($past(wd[0]) ? 16'h6363 : 16'h0000));
    endproperty
    a_preset: assert property (p_preset) else $error("checksum start wrong");
    property p_sync;
        wr_ack && idx == IDX_GENERAL_MODE |=> sync_byte_enable == $past(wd[6]) && sync_byte_value == 8'hF0;
    endproperty
    a_sync: assert property (p_sync) else $error("sync setting wrong");
    c_go: cover property (timer_go_strobe);
    c_halt: cover property (timer_halt_strobe);
    c_coll: cover property (rd_ack && idx == IDX_COLLISION_POS);
endmodule : ftm_regs_assertions

bind ftm_regs ftm_regs_assertions u_ftm_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_last_bits(rx_last_bits),
    .timer_running(timer_running), .timer_go_strobe(timer_go_strobe),
    .timer_halt_strobe(timer_halt_strobe), .sync_byte_enable(sync_byte_enable),
    .sync_byte_value(sync_byte_value), .checksum_start_value(checksum_start_value));

// File: tb/ftm_regs_test.sv
/* ftm_regs_test: directed bench for the watermark, timer, identifier and mode registers.
   Assumes the bind in ftm_regs_assertions and a 50 MHz clock. */
`timescale 1ns/1ps
module ftm_regs_test
    import ftm_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [2:0]  rx_last_bits = 3'h0;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, timer_running, high_first, det_off, near_full, near_empty, irq;
    wire  [15:0] checksum_start_value;
    int          failures = 0;
    int          total_checks = 0;
    logic [7:0]  rd;

    ftm_regs dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .rx_last_bits(rx_last_bits), .timer_running(timer_running), .timer_go_strobe(),
        .timer_halt_strobe(), .checksum_high_bit_first(high_first), .sync_byte_enable(),
        .sync_byte_value(), .mode_detector_disable(det_off),
        .checksum_start_value(checksum_start_value), .fifo_near_full_flag(near_full),
        .fifo_near_empty_flag(near_empty), .irq(irq));

    initial begin
        forever #10 mclk = ~mclk;
    end

    // one bus access; held until waitrequest is seen low, then one idle edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        avs_address   <= {idx, 2'b00};
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= {24'h000000, wd};
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) failures++;
        rd = avs_readdata[7:0];
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : xfer

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic rdchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(name, {24'h0, exp}, {24'h0, rd});
    endtask : rdchk

    task automatic test_reset;
        rdchk("watermark", IDX_FIFO_WATERMARK, 8'h08);
        rdchk("misc", IDX_MISC_CONTROL, 8'h00);
        rdchk("mode", IDX_GENERAL_MODE, 8'h3B);
        chk("preset", 32'hFFFF, {16'h0, checksum_start_value});
        rdchk("irq status", IDX_IRQ_STATUS, 8'h00);
        $display("test_reset done");
    endtask : test_reset

    // watermark two: near-empty above two bytes drops, near-full at 62 bytes
    task automatic test_fifo;
        xfer(1'b1, IDX_FIFO_WATERMARK, 8'hFF);
        rdchk("wm mask", IDX_FIFO_WATERMARK, 8'h3F);
        xfer(1'b1, IDX_FIFO_WATERMARK, 8'h02);
        for (int i = 1; i <= 62; i++) begin
            xfer(1'b1, IDX_FIFO_DATA_PORT, 8'(i));
            chk("near empty", 32'(i <= 2), {31'h0, near_empty});
            chk("near full", 32'(i >= 62), {31'h0, near_full});
        end
        rdchk("level", IDX_FIFO_LEVEL, 8'd62);
        rdchk("first byte", IDX_FIFO_DATA_PORT, 8'h01);
        chk("near full", 32'h0, {31'h0, near_full});
        xfer(1'b1, IDX_FIFO_LEVEL, 8'h80);
        rdchk("flushed", IDX_FIFO_LEVEL, 8'h00);
        $display("test_fifo done");
    endtask : test_fifo

    // running follows one edge after the strobe write commits
    task automatic timer_write(input logic [7:0] wd, input logic exp);
        xfer(1'b1, IDX_MISC_CONTROL, wd);
        repeat (2) @(posedge mclk);
        chk("running", {31'h0, exp}, {31'h0, timer_running});
    endtask : timer_write

    task automatic test_timer;
        rx_last_bits <= 3'h5;
        timer_write(8'h40, 1'b1);
        rdchk("misc read", IDX_MISC_CONTROL, 8'h05);
        timer_write(8'h98, 1'b0);
        rdchk("misc zero", IDX_MISC_CONTROL, 8'h05);
        timer_write(8'h40, 1'b1);
        timer_write(8'hC0, 1'b0);
        $display("test_timer done");
    endtask : test_timer

    task automatic test_card_id;
        int n;
        for (int i = 0; i < 10; i++) xfer(1'b1, IDX_CARD_ID_BASE + 8'(i), 8'hA0 + 8'(i));
        xfer(1'b1, IDX_IRQ_ENABLE, 8'h04);
        xfer(1'b1, IDX_MISC_CONTROL, 8'h20);
        n = 0;
        do begin
            xfer(1'b0, IDX_MISC_CONTROL, 8'h00);
            n++;
        end while (rd[5] !== 1'b0 && n < 20);
        chk("load bit", 32'h0, {31'h0, rd[5]});
        chk("irq set", 32'h1, {31'h0, irq});
        rdchk("id level", IDX_FIFO_LEVEL, 8'd10);
        for (int i = 0; i < 10; i++) rdchk("id byte", IDX_FIFO_DATA_PORT, 8'hA0 + 8'(i));
        xfer(1'b1, IDX_IRQ_CLEAR, 8'h04);
        chk("irq clear", 32'h0, {31'h0, irq});
        xfer(1'b1, IDX_IRQ_ENABLE, 8'h00);
        xfer(1'b1, IDX_MISC_CONTROL, 8'h20);
        repeat (15) @(posedge mclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        xfer(1'b1, IDX_IRQ_ENABLE, 8'h04);
        chk("irq unmask", 32'h1, {31'h0, irq});
        xfer(1'b1, IDX_IRQ_CLEAR, 8'h04);
        xfer(1'b1, IDX_FIFO_LEVEL, 8'h80);
        $display("test_card_id done");
    endtask : test_card_id

    task automatic test_mode;
        logic [15:0] pre [4];
        logic [7:0]  wd;
        pre = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
        for (int c = 0; c < 4; c++) begin
            wd = {c[0], c[1], 3'b101, c[0], 2'(c)};
            xfer(1'b1, IDX_GENERAL_MODE, wd);
            chk("preset", {16'h0, pre[c]}, {16'h0, checksum_start_value});
            chk("high first", {31'h0, wd[7]}, {31'h0, high_first});
            chk("det off", {31'h0, wd[2]}, {31'h0, det_off});
            rdchk("mode rb", IDX_GENERAL_MODE, wd);
        end
        xfer(1'b1, IDX_GENERAL_MODE, 8'h3B);
        $display("test_mode done");
    endtask : test_mode

    task automatic test_coll;
        xfer(1'b0, IDX_COLLISION_POS, 8'h00);
        chk("coll", 32'h5, {29'h0, rd[7:5]});
        xfer(1'b1, IDX_COLLISION_POS, 8'hA0);
        xfer(1'b0, IDX_COLLISION_POS, 8'h00);
        chk("coll kept", 32'h5, {29'h0, rd[7:5]});
        rdchk("unmapped", 8'h3F, 8'h00);
        $display("test_coll done");
    endtask : test_coll

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    // watchdog: far beyond the few hundred cycles the tests need
    initial begin
        repeat (30000) @(posedge mclk);
        failures++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        test_reset();
        test_fifo();
        test_timer();
        test_card_id();
        test_mode();
        test_coll();
        complete_run();
    end
endmodule : ftm_regs_test
